// ===== verilog/lcu_pkg.sv
// package: register map, field positions and carriers for the logic cell unit
package lcu_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] LCU_CTRL_OFS = 8'h00;
  localparam logic [7:0] LCU_IRQ_STAT_OFS = 8'h04;
  localparam logic [7:0] LCU_IRQ_MASK_OFS = 8'h08;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int LCU_GATE_INV_LSB = 16;
  localparam int LCU_ENABLE_BIT = 15;
  localparam int LCU_IDLE_BIT = 13;
  localparam int LCU_RISE_BIT = 11;
  localparam int LCU_FALL_BIT = 10;
  localparam int LCU_PIN_BIT = 7;
  localparam int LCU_LEVEL_BIT = 6;
  localparam int LCU_OINV_BIT = 5;
  localparam int LCU_MODE_LSB = 0;
  // writable bits; everything else reads zero except the level bit 6, which reads the cell output
  localparam logic [31:0] LCU_CTRL_WMASK = 32'h000F_ACA7;
  localparam logic [31:0] LCU_CTRL_RESET = 32'h0000_0000;

  // interrupt status / mask layout
  localparam int LCU_IRQ_RISE = 0;
  localparam int LCU_IRQ_FALL = 1;
  localparam logic [1:0] LCU_IRQ_RESET = 2'h0;

  // ----------------------------------------------------------------
  // cell functions
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LCU_AND_OR = 3'b000,
    LCU_OR_XOR = 3'b001,
    LCU_AND4 = 3'b010,
    LCU_SR_LATCH = 3'b011,
    LCU_DFF_SR = 3'b100,
    LCU_DFF2_R = 3'b101,
    LCU_JK_R = 3'b110,
    LCU_DLATCH_SR = 3'b111
  } lcu_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } lcu_bus_req_t;

  typedef struct packed {
    logic [3:0] gate_inv;
    logic enable;
    logic stop_in_idle;
    logic rise_irq_enable;
    logic fall_irq_enable;
    logic pin_drive_enable;
    logic output_invert;
    lcu_mode_t mode;
  } lcu_cfg_t;

endpackage

// ===== verilog/lcu_cell.sv
// combinational and sequential function core of the logic cell unit
`timescale 1ns/1ns
module lcu_cell (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] gate,
  input wire lcu_pkg::lcu_mode_t mode,
  input wire logic run,
  input wire logic clear,
  output logic q
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic q;
    logic clk_prev;
  } lcu_cell_state_t;

  lcu_cell_state_t s_reg;
  lcu_cell_state_t s_next;
  logic comb_out;
  logic rise;

  // gate(0) acts as clock for the flip-flop functions, sampled in CLK domain
  assign rise = gate[0] & ~s_reg.clk_prev;

  always_comb begin
    s_next = s_reg;
    comb_out = 1'b0;
    s_next.clk_prev = gate[0];
    case (mode)
      lcu_pkg::LCU_AND_OR: begin
        comb_out = (gate[0] & gate[1]) | (gate[2] & gate[3]);
      end
      lcu_pkg::LCU_OR_XOR: begin
        comb_out = (gate[0] | gate[1]) ^ (gate[2] | gate[3]);
      end
      lcu_pkg::LCU_AND4: begin
        comb_out = &gate;
      end
      lcu_pkg::LCU_SR_LATCH: begin
        // set = g1|g2, reset = g3|g4; set dominates [R11] [R14]
        if (gate[0] | gate[1]) begin
          s_next.q = 1'b1;
        end else if (gate[2] | gate[3]) begin
          s_next.q = 1'b0;
        end
      end
      lcu_pkg::LCU_DFF_SR: begin
        // clk g1, d g2, reset g3, set g4; reset dominates [R11] [R14]
        if (gate[2]) begin
          s_next.q = 1'b0;
        end else if (gate[3]) begin
          s_next.q = 1'b1;
        end else if (rise) begin
          s_next.q = gate[1];
        end
      end
      lcu_pkg::LCU_DFF2_R: begin
        // clk g1, d = g2 & g4, reset g3 [R12] [R14]
        if (gate[2]) begin
          s_next.q = 1'b0;
        end else if (rise) begin
          s_next.q = gate[1] & gate[3];
        end
      end
      lcu_pkg::LCU_JK_R: begin
        // clk g1, j g2, reset g3, k g4 [R12] [R14]
        if (gate[2]) begin
          s_next.q = 1'b0;
        end else if (rise) begin
          s_next.q = (gate[1] & ~s_reg.q) | (~gate[3] & s_reg.q);
        end
      end
      lcu_pkg::LCU_DLATCH_SR: begin
        // enable g1, d g2, reset g3, set g4 [R12] [R14]
        if (gate[2]) begin
          s_next.q = 1'b0;
        end else if (gate[3]) begin
          s_next.q = 1'b1;
        end else if (gate[0]) begin
          s_next.q = gate[1];
        end
      end
      default: begin
        comb_out = 1'b0;
      end
    endcase
    if (mode <= lcu_pkg::LCU_AND4) begin
      s_next.q = comb_out; // [R10]
    end
    if (!run) begin
      s_next = s_reg;
    end
    if (clear) begin
      s_next = '0; // [R14]
      // keep tracking channel one, so enabling on a high level is no false clock edge
      s_next.clk_prev = gate[0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.q;

endmodule

// ===== verilog/lcu_top.sv
// top of the logic cell unit: register port, polarity, interrupts, pin drive
// ----------------------------------------------------------------
// Functional notes
// R01: gate invert bit one inverts that gate channel before the cell
// R02: enable zero disables the cell and forces all outputs low; IRQ still follows pending status and mask
// R03: stop_in_idle one halts the cell while the device idles
// R04: rise_irq_enable raises an interrupt on output level low to high
// R05: fall_irq_enable raises an interrupt on output level high to low
// R06: software should not set both edge interrupt enables together
// R07: pin_drive_enable gates the cell output onto its port pin
// R08: cell_output_level is read-only, follows the cell output, writes ignored
// R09: output_invert inverts the final module output
// R10: modes 000 to 010 are AND-OR, OR-XOR, four-input AND
// R11: mode 011 SR latch, mode 100 D flip-flop with set and reset
// R12: modes 101 two-input D, 110 JK, 111 transparent latch, with reset
// R13: unimplemented control bits, 31 down to 20 included, read zero
// R14: gates feed data, clock, set, reset, J, K; disable clears state
// ----------------------------------------------------------------
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
module lcu_top (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic [3:0] GATE_IN,
  input wire logic IDLE,
  output logic CELL_OUT,
  output logic PIN_OUT,
  output logic PIN_OE,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] ctrl;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [31:0] rdata;
    logic level_prev;
    logic cell_out;
    logic pin_out;
    logic pin_oe;
    logic irq;
  } lcu_state_t;

  lcu_state_t s_reg;
  lcu_state_t s_next;
  lcu_pkg::lcu_bus_req_t req;
  lcu_pkg::lcu_cfg_t cfg;
  logic [3:0] gate_adj;
  logic cell_q;
  logic run;
  logic level;
  logic [1:0] irq_event;

  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  assign cfg.gate_inv = s_reg.ctrl[lcu_pkg::LCU_GATE_INV_LSB +: 4];
  assign cfg.enable = s_reg.ctrl[lcu_pkg::LCU_ENABLE_BIT];
  assign cfg.stop_in_idle = s_reg.ctrl[lcu_pkg::LCU_IDLE_BIT];
  assign cfg.rise_irq_enable = s_reg.ctrl[lcu_pkg::LCU_RISE_BIT];
  assign cfg.fall_irq_enable = s_reg.ctrl[lcu_pkg::LCU_FALL_BIT];
  assign cfg.pin_drive_enable = s_reg.ctrl[lcu_pkg::LCU_PIN_BIT];
  assign cfg.output_invert = s_reg.ctrl[lcu_pkg::LCU_OINV_BIT];
  assign cfg.mode = lcu_pkg::lcu_mode_t'(s_reg.ctrl[lcu_pkg::LCU_MODE_LSB +: 3]);

  // ----------------------------------------------------------------
  // per-channel polarity
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_pol
    assign gate_adj[i] = GATE_IN[i] ^ cfg.gate_inv[i]; // [R01]
  end

  // idle stop freezes the cell state rather than clearing it
  assign run = cfg.enable & ~(cfg.stop_in_idle & IDLE); // [R03]

  lcu_cell u_cell (
    .clk(CLK),
    .resetn(RESETN),
    .gate(gate_adj),
    .mode(cfg.mode),
    .run(run),
    .clear(~cfg.enable),
    .q(cell_q)
  );

  // disabled cell shows zero everywhere, polarity not applied [R02]
  assign level = cfg.enable & (cell_q ^ cfg.output_invert); // [R09]

  // both enables set gives an event on every toggle; software avoids it [R06]
  assign irq_event[lcu_pkg::LCU_IRQ_RISE] =
    cfg.rise_irq_enable & level & ~s_reg.level_prev; // [R04]
  assign irq_event[lcu_pkg::LCU_IRQ_FALL] =
    cfg.fall_irq_enable & ~level & s_reg.level_prev; // [R05]

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.rdata = 32'h0000_0000;
    s_next.level_prev = level;
    s_next.cell_out = level;
    s_next.pin_oe = cfg.pin_drive_enable & cfg.enable; // [R07]
    s_next.pin_out = cfg.pin_drive_enable & level; // [R07]

    if (req.wr) begin
      case (req.addr)
        lcu_pkg::LCU_CTRL_OFS: begin
          s_next.ctrl = req.wdata & lcu_pkg::LCU_CTRL_WMASK; // [R13]
        end
        lcu_pkg::LCU_IRQ_STAT_OFS: begin
          s_next.irq_stat = s_reg.irq_stat & ~req.wdata[1:0];
        end
        lcu_pkg::LCU_IRQ_MASK_OFS: begin
          s_next.irq_mask = req.wdata[1:0];
        end
        default: begin
          s_next.ctrl = s_reg.ctrl;
        end
      endcase
    end
    // set wins over a clear in the same cycle
    s_next.irq_stat = s_next.irq_stat | irq_event;

    if (req.rd) begin
      case (req.addr)
        lcu_pkg::LCU_CTRL_OFS: begin
          s_next.rdata = s_reg.ctrl;
          s_next.rdata[lcu_pkg::LCU_LEVEL_BIT] = s_reg.level_prev; // [R08]
        end
        lcu_pkg::LCU_IRQ_STAT_OFS: begin
          s_next.rdata = {30'h0000_0000, s_reg.irq_stat};
        end
        lcu_pkg::LCU_IRQ_MASK_OFS: begin
          s_next.rdata = {30'h0000_0000, s_reg.irq_mask};
        end
        default: begin
          s_next.rdata = 32'h0000_0000;
        end
      endcase
    end
    s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign RDATA = s_reg.rdata;
  assign CELL_OUT = s_reg.cell_out;
  assign PIN_OUT = s_reg.pin_out;
  assign PIN_OE = s_reg.pin_oe;
  assign IRQ = s_reg.irq;

endmodule

// ===== tb/lcu_props.sv
// checker: port-level properties of the logic cell unit
`timescale 1ns/1ns
module lcu_props (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic [3:0] GATE_IN,
  input wire logic IDLE,
  input wire logic CELL_OUT,
  input wire logic PIN_OUT,
  input wire logic PIN_OE,
  input wire logic IRQ
);
  logic [31:0] c_reg;
  logic [1:0] m_reg;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // ----------------------------------------------------------------
  // shadow of control and mask writes, seen only through the bus
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      c_reg <= 32'h0;
      m_reg <= 2'h0;
    end else if (WR && ADDR == 8'h00) begin
      c_reg <= WDATA;
    end else if (WR && ADDR == 8'h08) begin
      m_reg <= WDATA[1:0];
    end
  end
  a_pin_gated: assert property (!PIN_OE |-> !PIN_OUT)
    else $error("pin value set while not driven");
  a_pin_follows: assert property (PIN_OE |-> PIN_OUT == CELL_OUT)
    else $error("pin value differs from cell output");
  a_high_bits_zero: assert property ($past(RD) |-> RDATA[31:20] == 12'h0)
    else $error("unimplemented bits read nonzero");
  a_level_bit: assert property ($past(RD) && $past(ADDR) == 8'h00 |-> RDATA[6] == $past(CELL_OUT))
    else $error("level bit differs from output");
  a_off_low: assert property (!$past(c_reg[15]) && !$past(c_reg[15], 2) |-> !CELL_OUT)
    else $error("output high while disabled");
  a_mask_blocks: assert property (m_reg == 2'h0 && $past(m_reg) == 2'h0 |-> !IRQ)
    else $error("interrupt with all masked");
  a_rise_irq: assert property ($rose(CELL_OUT) && c_reg[11] && $past(c_reg[11]) && m_reg[0] && $past(m_reg[0]) |-> IRQ)
    else $error("no interrupt on rising output");
  a_fall_irq: assert property ($fell(CELL_OUT) && c_reg[10] && $past(c_reg[10]) && m_reg[1] && $past(m_reg[1]) |-> IRQ)
    else $error("no interrupt on falling output");
endmodule

bind lcu_top lcu_props lcu_props_inst (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .GATE_IN(GATE_IN), .IDLE(IDLE), .CELL_OUT(CELL_OUT),
  .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .IRQ(IRQ));

// ===== tb/lcu_pin_model.sv
// port pin model with a weak pull-down
`timescale 1ns/1ns
module lcu_pin_model (
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pin_level
);
  // an undriven pin settles to the pull-down level, never to the last value
  assign pin_level = pin_oe ? pin_out : 1'b0;
endmodule

// ===== tb/tb_lcu_top.sv
// self-checking testbench of the logic cell unit
`timescale 1ns/1ns
module tb_lcu_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] gate = 4'h0;
  logic idle = 1'b0;
  logic [31:0] rdata;
  logic cell_out, pin_out, pin_oe, irq, pin_level;
  int err_count = 0;
  int checks_done = 0;
  always #5 clk = ~clk;
  lcu_top lcu_top_inst (.CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .GATE_IN(gate), .IDLE(idle), .CELL_OUT(cell_out),
    .PIN_OUT(pin_out), .PIN_OE(pin_oe), .IRQ(irq));
  lcu_pin_model lcu_pin_model_inst (.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(e, rdata);
  endtask
  // four edges cover the two-stage path plus edge detection
  task automatic drive(input logic [3:0] g);
    @(posedge clk);
    gate <= g;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic comb(input logic [2:0] m, input logic [31:0] x, input logic [3:0] g,
    input logic e);
    wr_reg(8'h00, 32'h8000 | x | {29'h0, m});
    drive(g);
    chk(32'(e), 32'(cell_out));
    chk(32'(e & x[7]), 32'(pin_level));
  endtask
  task automatic summarize;
    $display("errors=%0d checks=%0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd_chk(8'h00, 32'h0);
    wr_reg(8'h00, 32'hFFFF_7BFF); // rise enable only, never both edge enables
    rd_chk(8'h00, 32'h000F_28A7);
    chk(32'h0, 32'(cell_out));
    rd_chk(8'h0C, 32'h0);
  endtask
  task automatic t_comb;
    comb(3'b010, 32'h000F_0080, 4'h0, 1'b1);
    rd_chk(8'h00, 32'h000F_80C2);
    comb(3'b010, 32'h000F_0080, 4'h1, 1'b0);
    comb(3'b010, 32'h0000_00A0, 4'hF, 1'b0);
    comb(3'b000, 32'h0000_0080, 4'h3, 1'b1);
    comb(3'b000, 32'h0000_0080, 4'h5, 1'b0);
    comb(3'b001, 32'h0000_0080, 4'h1, 1'b1);
    comb(3'b001, 32'h0000_0080, 4'h5, 1'b0);
    comb(3'b000, 32'h0, 4'hC, 1'b1);
  endtask
  task automatic t_irq;
    wr_reg(8'h08, 32'h3);
    comb(3'b010, 32'h0880, 4'h0, 1'b0);
    drive(4'hF);
    chk(32'h1, 32'(irq));
    rd_chk(8'h04, 32'h1);
    wr_reg(8'h04, 32'h1);
    comb(3'b010, 32'h0480, 4'hF, 1'b1);
    chk(32'h0, 32'(irq));
    drive(4'h0);
    rd_chk(8'h04, 32'h2);
    wr_reg(8'h08, 32'h0);
    drive(4'h0);
    chk(32'h0, 32'(irq));
    wr_reg(8'h04, 32'h2);
    drive(4'hF);
    rd_chk(8'h04, 32'h0);
  endtask
  task automatic t_idle;
    comb(3'b010, 32'h2080, 4'h0, 1'b0);
    idle <= 1'b1;
    drive(4'hF);
    chk(32'h0, 32'(cell_out));
    idle <= 1'b0;
    drive(4'hF);
    chk(32'h1, 32'(cell_out));
    comb(3'b010, 32'h0080, 4'h0, 1'b0);
    idle <= 1'b1;
    drive(4'hF);
    chk(32'h1, 32'(cell_out));
    idle <= 1'b0;
  endtask
  task automatic t_seq;
    logic [3:0] g;
    for (int m = 3; m < 8; m++) begin
      g = (m == 5) ? 4'hA : 4'h2;
      comb(m[2:0], 32'h0080, 4'h4, 1'b0);
      drive(g);
      drive(g | 4'h1);
      chk(32'h1, 32'(cell_out));
      drive(4'h0);
      wr_reg(8'h00, {29'h0, m[2:0]});
      comb(m[2:0], 32'h0080, 4'h0, 1'b0);
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_comb();
    t_irq();
    t_idle();
    t_seq();
    summarize();
  end
  initial begin
    #100000;
    err_count++;
    summarize();
  end
endmodule
